/* urxf_pkg.sv */
/*
 * Shared constants and types for the receive channel.
 * Assumes a single 100 MHz clock; serial bit timing comes from a 16x tick input.
 */
package urxf_pkg;
    localparam int URXF_FIFO_DEPTH = 3;
    localparam int URXF_PTR_W = 2;
    localparam logic [1:0] URXF_PM_MULTIDROP = 2'h3;
    localparam logic [3:0] URXF_START_CHECK = 4'h7;
    localparam logic [3:0] URXF_BIT_TICKS_M1 = 4'hf;
    localparam logic [7:0] URXF_DATA_RST = 8'h00;
    localparam int URXF_SR_FULL_BIT = 1;
    localparam int URXF_SR_PAR_BIT = 5;

    // First mode register fields used by this block.
    typedef struct packed {
        logic rx_rtr_en;     // Bit 7: automatic ready-to-receive.
        logic irq_sel;       // Bit 6: interrupt source select, not used by this block.
        logic err_block;     // Bit 5: block error mode.
        logic [1:0] par_mode;// Bits 4:3.
        logic par_type;      // Bit 2: parity sense or transmitted tag.
        logic [1:0] bits_m5; // Bits 1:0: character length minus five.
    } urxf_mode_s;

    // One FIFO entry: data and its three appended status bits.
    typedef struct packed {
        logic brk;
        logic ferr;
        logic perr;
        logic [7:0] data;
    } urxf_entry_s;

    typedef enum logic [1:0] {
        URXF_CHAN_NORMAL = 2'b00,
        URXF_CHAN_ECHO = 2'b01,
        URXF_CHAN_LOCAL = 2'b10,
        URXF_CHAN_REMOTE = 2'b11
    } urxf_chan_e;

    typedef enum logic [2:0] {
        URXF_IDLE = 3'b000,
        URXF_START = 3'b001,
        URXF_DATA = 3'b010,
        URXF_PAR = 3'b011,
        URXF_STOP = 3'b100,
        URXF_BRKWAIT = 3'b101
    } urxf_rx_e;
endpackage : urxf_pkg

/* urxf_fifo.sv */
/*
 * Three-entry receive holding stack with registered head output.
 * Assumes push and pop are qualified by the owner against full and empty.
 */
module urxf_fifo
    import urxf_pkg::*;
(
    input wire logic i_mclk,                 // System clock.
    input wire logic i_rst_n,                // Synchronised reset, active low.
    input wire logic i_ce,                   // Clock enable.
    input wire logic i_clr,                  // Empty the stack.
    input wire logic i_push,                 // Write one entry.
    input wire urxf_entry_s i_wdata,         // Entry to write.
    input wire logic i_pop,                  // Remove the head entry.
    output urxf_entry_s o_head,              // Head entry, registered.
    output logic [URXF_PTR_W-1:0] o_count    // Entries held.
);
    urxf_entry_s mem_ff [URXF_FIFO_DEPTH];
    urxf_entry_s nxt_mem [URXF_FIFO_DEPTH];
    logic [URXF_PTR_W-1:0] cnt_ff;
    logic [URXF_PTR_W-1:0] nxt_cnt;
    logic [URXF_PTR_W-1:0] wr_idx;

    // Shift register stack: head always in slot zero, so the head read is a register.
    always_comb
    begin
        nxt_mem = mem_ff;
        nxt_cnt = cnt_ff;
        wr_idx = cnt_ff;
        if (i_clr)
        begin
            nxt_cnt = '0;
        end
        else
        begin
            if (i_pop)
            begin
                for (int k = 0; k < URXF_FIFO_DEPTH - 1; k++)
                begin
                    nxt_mem[k] = mem_ff[k + 1];
                end
                wr_idx = cnt_ff - 2'h1;
            end
            if (i_push)
            begin
                nxt_mem[wr_idx] = i_wdata;
            end
            nxt_cnt = cnt_ff + {1'b0, i_push} - {1'b0, i_pop};
        end
    end

    // Registers only.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_ff <= '0;
            for (int k = 0; k < URXF_FIFO_DEPTH; k++)
            begin
                mem_ff[k] <= '0;
            end
        end
        else if (i_ce)
        begin
            cnt_ff <= nxt_cnt;
            mem_ff <= nxt_mem;
        end
    end

    assign o_head = mem_ff[0];
    assign o_count = cnt_ff;
endmodule : urxf_fifo

/* urxf_rx.sv */
/*
 * Receive channel: serial assembly, holding stack, overrun, block error
 * status, automatic ready-to-receive, looping modes and multidrop wake-up.
 * Assumes a 16x bit tick from an outside baud generator on the same clock and
 * a transmitter elsewhere that supplies its serial output and takes the tag.
 */
module urxf_rx
    import urxf_pkg::*;
(
    input wire logic i_mclk,               // System clock, 100 MHz.
    input wire logic i_rst_n,              // Asynchronous reset, active low.
    input wire logic i_ce,                 // Clock enable; low freezes all state except the reset and line synchronisers.
    input wire logic i_tick16,             // 16x bit tick, one-cycle pulse.
    input wire logic i_rxd,                // Serial line input pin.
    input wire logic i_tx_serial,          // Internal transmitter serial output.
    output logic o_txd,                    // Serial line output pin.
    output logic o_tx_host_en,             // Host may load the transmitter.
    output logic o_tx_tag,                 // Tag bit the transmitter sends.
    output logic o_tx_par_off,             // Transmitter sends no parity.
    input wire urxf_mode_s i_mode,         // First mode register contents.
    input wire urxf_chan_e i_chan_mode,    // Looping mode select.
    input wire logic i_rx_en_cmd,          // Receiver enable command pulse.
    input wire logic i_rx_dis_cmd,         // Receiver disable command pulse.
    input wire logic i_rx_rst_cmd,         // Receiver reset command pulse.
    input wire logic i_err_rst_cmd,        // Reset-error command pulse.
    input wire logic i_rtr_set,            // Software asserts ready-to-receive.
    input wire logic i_rd_buf,             // Host reads receive buffer.
    output logic [7:0] o_rx_data,          // Head character data.
    output logic [7:0] o_status,           // Channel status register view.
    output logic o_ready_to_receive_out_n, // Ready-to-receive pin, active low.
    output logic o_rx_irq                  // Receiver ready interrupt request.
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;
    logic rxd_meta_ff;
    logic rxd_sync_ff;

    // Reset release through two flops; line pin through a two-flop synchroniser.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
            rxd_meta_ff <= 1'b1;
            rxd_sync_ff <= 1'b1;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
            rxd_meta_ff <= i_rxd;
            rxd_sync_ff <= rxd_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    logic md_mode;
    logic line_in;
    assign md_mode = (i_mode.par_mode == URXF_PM_MULTIDROP);
    assign o_tx_tag = i_mode.par_type;
    assign o_tx_par_off = md_mode;

    // Looping paths; local loopback takes the transmitter, others the line.
    always_comb
    begin
        line_in = rxd_sync_ff;
        o_txd = i_tx_serial;
        o_tx_host_en = 1'b1;
        case (i_chan_mode)
            URXF_CHAN_ECHO:
            begin
                o_txd = rxd_sync_ff;
                o_tx_host_en = 1'b0;
            end
            URXF_CHAN_LOCAL:
            begin
                line_in = i_tx_serial;
                o_txd = 1'b1;
            end
            URXF_CHAN_REMOTE:
            begin
                o_txd = rxd_sync_ff;
                o_tx_host_en = 1'b0;
            end
            default:
            begin
                line_in = rxd_sync_ff;
            end
        endcase
    end

    // Receiver state.
    urxf_rx_e st_ff, nxt_st;
    logic [3:0] tk_ff, nxt_tk;
    logic [2:0] bit_ff, nxt_bit;
    logic [7:0] sh_ff, nxt_sh;
    logic par_ff, nxt_par;
    logic en_ff, nxt_en;
    logic hold_ff, nxt_hold;
    urxf_entry_s hold_ent_ff, nxt_hold_ent;
    logic ovr_ff, nxt_ovr;
    logic [2:0] acc_ff, nxt_acc;
    logic rtr_ff, nxt_rtr;
    logic rtr_arm_ff, nxt_rtr_arm;
    logic acc_pend_ff, nxt_acc_pend;
    logic push;
    urxf_entry_s push_ent;
    logic pop;
    logic fifo_clr;
    urxf_entry_s head;
    logic [URXF_PTR_W-1:0] cnt;
    logic fifo_full;
    logic host_cut;
    logic listen;
    logic bit_mid;
    logic [2:0] last_bit;
    logic data_zero;

    assign host_cut = (i_chan_mode == URXF_CHAN_REMOTE);
    assign fifo_full = (cnt == URXF_PTR_W'(URXF_FIFO_DEPTH));
    assign pop = i_rd_buf && (cnt != '0) && !host_cut;
    assign listen = en_ff || md_mode;
    assign bit_mid = i_tick16 && (tk_ff == URXF_BIT_TICKS_M1);
    assign last_bit = 3'(4 + i_mode.bits_m5);
    assign data_zero = (sh_ff == 8'h00) && !par_ff;

    // Character assembly, waiting character, overrun and flow control.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_tk = tk_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_par = par_ff;
        nxt_en = en_ff;
        nxt_hold = hold_ff;
        nxt_hold_ent = hold_ent_ff;
        nxt_ovr = ovr_ff;
        nxt_rtr = rtr_ff;
        nxt_rtr_arm = rtr_arm_ff;
        push = 1'b0;
        push_ent = hold_ent_ff;
        fifo_clr = 1'b0;
        // Clearing first lets an overrun that lands in the same cycle survive.
        if (i_err_rst_cmd)
        begin
            nxt_ovr = 1'b0;
        end
        if (i_tick16)
        begin
            nxt_tk = tk_ff + 4'h1;
        end
        // Waiting character moves in as soon as a slot opens.
        if (hold_ff && (!fifo_full || pop))
        begin
            push = 1'b1;
            nxt_hold = 1'b0;
        end
        case (st_ff)
            URXF_IDLE:
            begin
                if (listen && i_tick16 && !line_in)
                begin
                    nxt_st = URXF_START;
                    nxt_tk = 4'h0;
                end
            end
            URXF_START:
            begin
                if (i_tick16 && tk_ff == URXF_START_CHECK - 4'h1)
                begin
                    if (line_in)
                    begin
                        nxt_st = URXF_IDLE;
                    end
                    else
                    begin
                        nxt_st = URXF_DATA;
                        nxt_tk = 4'h0;
                        nxt_bit = 3'h0;
                        nxt_sh = URXF_DATA_RST;
                        nxt_par = 1'b0;
                        if (hold_ff && !push)
                        begin
                            nxt_hold = 1'b0;
                            nxt_ovr = 1'b1;
                        end
                        if (i_mode.rx_rtr_en && fifo_full && !pop)
                        begin
                            nxt_rtr = 1'b0;
                        end
                    end
                end
            end
            URXF_DATA:
            begin
                if (bit_mid)
                begin
                    nxt_sh[bit_ff] = line_in;
                    nxt_bit = bit_ff + 3'h1;
                    if (bit_ff == last_bit)
                    begin
                        nxt_st = (i_mode.par_mode[1] && !md_mode) || md_mode
                            ? URXF_PAR : URXF_STOP;
                    end
                end
            end
            URXF_PAR:
            begin
                if (bit_mid)
                begin
                    nxt_par = line_in;
                    nxt_st = URXF_STOP;
                end
            end
            URXF_STOP:
            begin
                if (bit_mid)
                begin
                    nxt_st = line_in ? URXF_IDLE : URXF_BRKWAIT;
                    nxt_hold_ent.data = sh_ff;
                    nxt_hold_ent.ferr = !line_in && !data_zero;
                    nxt_hold_ent.brk = !line_in && data_zero;
                    nxt_hold_ent.perr = md_mode ? par_ff :
                        (i_mode.par_mode[1] && ((^sh_ff) ^ par_ff ^ !i_mode.par_type));
                    // Disabled multidrop listeners keep only address characters.
                    nxt_hold = en_ff || (md_mode && par_ff);
                    if (!(en_ff || (md_mode && par_ff)))
                    begin
                        nxt_hold = 1'b0;
                    end
                end
            end
            URXF_BRKWAIT:
            begin
                // Line must go back to mark before hunting for a new start.
                if (line_in)
                begin
                    nxt_st = URXF_IDLE;
                end
            end
            default:
            begin
                nxt_st = URXF_IDLE;
            end
        endcase
        // The pin is only handed to the receiver after software raised it once.
        if (i_rtr_set)
        begin
            nxt_rtr = 1'b1;
            nxt_rtr_arm = 1'b1;
        end
        else if (i_mode.rx_rtr_en && rtr_arm_ff && !rtr_ff && (!fifo_full || pop))
        begin
            nxt_rtr = 1'b1;
        end
        if (i_rx_en_cmd)
        begin
            nxt_en = 1'b1;
        end
        if (i_rx_dis_cmd)
        begin
            nxt_en = 1'b0;
            if (!md_mode)
            begin
                nxt_st = URXF_IDLE;
                nxt_hold = 1'b0;
                push = 1'b0;
            end
        end
        if (i_rx_rst_cmd)
        begin
            nxt_en = 1'b0;
            nxt_rtr_arm = 1'b0;
            nxt_st = URXF_IDLE;
            nxt_hold = 1'b0;
            nxt_ovr = 1'b0;
            nxt_rtr = 1'b0;
            push = 1'b0;
            fifo_clr = 1'b1;
        end
        push_ent = hold_ent_ff;
    end

    // Block error accumulation over every character reaching the head.
    always_comb
    begin
        nxt_acc = acc_ff;
        nxt_acc_pend = acc_pend_ff;
        // The clear comes first so a head arriving in the same cycle still counts.
        if (i_err_rst_cmd)
        begin
            nxt_acc = 3'h0;
        end
        // A new head appears after a pop with more behind, or a push into empty.
        if ((cnt != '0) && acc_pend_ff)
        begin
            nxt_acc = nxt_acc | {head.brk, head.ferr, head.perr};
            nxt_acc_pend = 1'b0;
        end
        if (pop || (cnt == '0))
        begin
            nxt_acc_pend = 1'b1;
        end
        if (i_rx_rst_cmd)
        begin
            nxt_acc = 3'h0;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff <= URXF_IDLE;
            tk_ff <= 4'h0;
            bit_ff <= 3'h0;
            sh_ff <= URXF_DATA_RST;
            par_ff <= 1'b0;
            en_ff <= 1'b0;
            hold_ff <= 1'b0;
            hold_ent_ff <= '0;
            ovr_ff <= 1'b0;
            acc_ff <= 3'h0;
            acc_pend_ff <= 1'b1;
            rtr_ff <= 1'b0;
            rtr_arm_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            st_ff <= nxt_st;
            tk_ff <= nxt_tk;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            par_ff <= nxt_par;
            en_ff <= nxt_en;
            hold_ff <= nxt_hold;
            hold_ent_ff <= nxt_hold_ent;
            ovr_ff <= nxt_ovr;
            acc_ff <= nxt_acc;
            acc_pend_ff <= nxt_acc_pend;
            rtr_ff <= nxt_rtr;
            rtr_arm_ff <= nxt_rtr_arm;
        end
    end

    urxf_fifo u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_clr(fifo_clr),
        .i_push(push),
        .i_wdata(push_ent),
        .i_pop(pop),
        .o_head(head),
        .o_count(cnt)
    );

    logic [2:0] err_view;
    // Per-character status shows only the head; block mode shows the running OR.
    always_comb
    begin
        if (i_mode.err_block)
        begin
            err_view = acc_ff | ((cnt != '0) ? {head.brk, head.ferr, head.perr} : 3'h0);
        end
        else
        begin
            err_view = (cnt != '0) ? {head.brk, head.ferr, head.perr} : 3'h0;
        end
        o_status = {err_view, ovr_ff, 2'h0, fifo_full, cnt != '0};
    end

    assign o_rx_data = host_cut ? 8'h00 : head.data;
    assign o_ready_to_receive_out_n = !rtr_ff;
    assign o_rx_irq = (cnt != '0) && !host_cut;

    // Overrun must follow a start seen while a character waits with the stack full.
    ovr_set_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && st_ff == URXF_START && nxt_st == URXF_DATA && hold_ff && !push
        && !i_rx_rst_cmd && !i_err_rst_cmd) |=> ovr_ff)
        else $error("overrun not set on start with waiting character");
    stat_read_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && !i_rd_buf && !push && !fifo_clr) |=> cnt == $past(cnt))
        else $error("stack changed without a buffer read");
    flow_drop_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && i_mode.rx_rtr_en && rtr_ff && !i_rtr_set && nxt_st == URXF_DATA
        && st_ff == URXF_START && fifo_full && !pop && !i_rx_rst_cmd) |=> !rtr_ff)
        else $error("ready-to-receive not dropped on full stack");
    loop_mark_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_chan_mode == URXF_CHAN_LOCAL) |-> o_txd)
        else $error("line output not at mark in local loopback");
    reset_clr_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && i_rx_rst_cmd) |=> (cnt == '0) && !ovr_ff && !en_ff && acc_ff == 3'h0)
        else $error("receiver reset left state behind");
    md_par_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && md_mode && st_ff == URXF_STOP && bit_mid)
        |=> hold_ent_ff.perr == $past(par_ff))
        else $error("tag not stored in place of parity");
    blk_sticky_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && acc_ff[1] && !i_err_rst_cmd && !i_rx_rst_cmd) |=> acc_ff[1])
        else $error("block framing flag lost");
    disable_drop_a: assert property (@(posedge i_mclk) disable iff (!rst_n)
        (i_ce && i_rx_dis_cmd && !md_mode) |=> !hold_ff && st_ff == URXF_IDLE)
        else $error("disable kept a character");
endmodule : urxf_rx

/* urxf_station.sv */
/*
 * Remote serial station model: sends whole characters on one line.
 * Assumes the 16x tick and clock of the bench.
 */
module urxf_station
(
    input wire logic i_mclk, // Bench clock.
    input wire logic i_tick16, // 16x bit tick.
    output logic o_line // Serial line, idle high.
);
    timeunit 1ns;
    timeprecision 100ps;

    // The line rests at mark between characters.
    initial o_line = 1'b1;

    // One bit cell is sixteen ticks; changes land just after an edge.
    task automatic bit_out(input logic b);
        int n;
        n = 0;
        o_line = b;
        while (n < 16)
        begin
            @(posedge i_mclk);
            n = n + int'(i_tick16);
        end
        #1;
    endtask : bit_out

    // Start, eight data bits LSB first, optional tag, stop, one idle bit.
    task automatic send(input logic [7:0] d, input logic xb, input logic ux,
                        input logic stop);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++)
            bit_out(d[i]);
        if (ux)
            bit_out(xb);
        bit_out(stop);
        bit_out(1'b1);
    endtask : send
endmodule : urxf_station

/* testbench.sv */
/*
 * Self-checking bench for the receive channel.
 * Assumes two station models: one on the line, one as transmitter.
 */
module testbench
    import urxf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_tick16 = 1'b0;
    logic [5:0] cmd = 6'h00;
    urxf_mode_s mode = 8'h00;
    urxf_chan_e chan = URXF_CHAN_NORMAL;
    logic line_rx, line_tx, txd, host_en, tag, par_off, irq, rtr_n;
    logic [7:0] rx_data, status;
    int error_cnt = 0;
    int n_checks = 0;

    // Clock, a tick on every second cycle, reset for eight cycles.
    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) i_tick16 <= #1 ~i_tick16;
    initial
    begin
        repeat (8) @(posedge i_mclk);
        #1 i_rst_n = 1'b1;
    end

    urxf_station st_rx (.i_mclk(i_mclk), .i_tick16(i_tick16), .o_line(line_rx));
    urxf_station st_tx (.i_mclk(i_mclk), .i_tick16(i_tick16), .o_line(line_tx));

    urxf_rx dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_tick16(i_tick16),
        .i_rxd(line_rx), .i_tx_serial(line_tx), .o_txd(txd), .o_tx_host_en(host_en),
        .o_tx_tag(tag), .o_tx_par_off(par_off), .i_mode(mode), .i_chan_mode(chan),
        .i_rx_en_cmd(cmd[0]), .i_rx_dis_cmd(cmd[1]), .i_rx_rst_cmd(cmd[2]),
        .i_err_rst_cmd(cmd[3]), .i_rtr_set(cmd[4]), .i_rd_buf(cmd[5]),
        .o_rx_data(rx_data), .o_status(status), .o_ready_to_receive_out_n(rtr_n),
        .o_rx_irq(irq));

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc

    // Command pulses: 0 enable, 1 disable, 2 reset, 3 error reset, 4 rtr, 5 read.
    task automatic pulse(input int k);
        cmd = 6'h01 << k;
        cyc(1);
        cmd = 6'h00;
        cyc(1);
    endtask : pulse

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] exp);
        chk(rx_data, exp, "head data");
        pulse(5);
    endtask : rd

    task automatic rx(input logic [7:0] d, input logic xb, input logic ux, input logic s);
        st_rx.send(d, xb, ux, s);
        cyc(4);
    endtask : rx

    // Echo is sampled mid-cell, so the synchroniser delay cannot matter.
    task automatic echo_chk(input logic [7:0] d);
        fork
            st_rx.send(d, 1'b0, 1'b0, 1'b1);
            begin
                cyc(16);
                repeat (9)
                begin
                    chk({7'h00, txd}, {7'h00, line_rx}, "echo");
                    cyc(32);
                end
            end
        join
        cyc(4);
    endtask : echo_chk

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // A hung run is cut short and reported as a mismatch.
    initial
    begin
        repeat (100000) @(posedge i_mclk);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end

    // Main sequence.
    initial
    begin
        cyc(12);
        chk(status, 8'h00, "reset status");
        chk({7'h00, rtr_n}, 8'h01, "rtr idle");
        mode = 8'h83;
        pulse(0);
        chk({7'h00, rtr_n}, 8'h01, "rtr waits for software");
        pulse(4);
        chk({7'h00, rtr_n}, 8'h00, "rtr set");
        for (int i = 0; i < 5; i++)
        begin
            rx(8'ha0 + 8'(i), 1'b0, 1'b0, 1'b1);
            if (i == 2)
                chk(status, 8'h03, "full");
            if (i == 3)
                chk({7'h00, rtr_n}, 8'h01, "rtr dropped");
        end
        chk(status, 8'h13, "overrun");
        chk(status, 8'h13, "status reread");
        rd(8'ha0);
        cyc(2);
        chk({7'h00, rtr_n}, 8'h00, "rtr back");
        rd(8'ha1);
        rd(8'ha2);
        rd(8'ha4);
        pulse(3);
        mode = 8'ha3;
        rx(8'h55, 1'b0, 1'b0, 1'b0);
        rx(8'h66, 1'b0, 1'b0, 1'b1);
        rd(8'h55);
        chk(status, 8'h41, "block ferr");
        rd(8'h66);
        pulse(3);
        chk(status, 8'h00, "error reset");
        mode = 8'h83;
        rx(8'h55, 1'b0, 1'b0, 1'b0);
        rx(8'h66, 1'b0, 1'b0, 1'b1);
        rd(8'h55);
        chk(status, 8'h01, "char mode");
        rd(8'h66);
        rx(8'h11, 1'b0, 1'b0, 1'b1);
        pulse(1);
        rx(8'h22, 1'b0, 1'b0, 1'b1);
        chk(status, 8'h01, "disabled");
        rd(8'h11);
        pulse(0);
        // Disable in the middle of a character: nothing may reach the stack.
        fork
            st_rx.send(8'h3c, 1'b0, 1'b0, 1'b1);
            begin
                cyc(120);
                pulse(1);
            end
        join
        cyc(4);
        chk(status, 8'h00, "cut mid character");
        pulse(0);
        rx(8'h33, 1'b0, 1'b0, 1'b1);
        pulse(2);
        chk({irq, rtr_n, status[5:0]}, 8'h40, "rx reset");
        rx(8'h44, 1'b0, 1'b0, 1'b1);
        chk(status, 8'h00, "halted");
        mode = 8'h9f;
        cyc(1);
        chk({6'h00, tag, par_off}, 8'h03, "tag and parity off");
        rx(8'h5a, 1'b0, 1'b1, 1'b1);
        chk(status, 8'h00, "data dropped");
        rx(8'h07, 1'b1, 1'b1, 1'b1);
        chk({irq, status[6:0]}, 8'ha1, "address kept");
        pulse(0);
        rx(8'h5b, 1'b0, 1'b1, 1'b0);
        rd(8'h07);
        chk(status, 8'h41, "tag clear, ferr");
        rd(8'h5b);
        mode = 8'h83;
        chan = URXF_CHAN_LOCAL;
        fork
            st_tx.send(8'hc2, 1'b0, 1'b0, 1'b1);
            begin
                cyc(40);
                chk({7'h00, txd}, 8'h01, "local mark");
            end
        join
        cyc(4);
        rd(8'hc2);
        chan = URXF_CHAN_ECHO;
        cyc(1);
        chk({7'h00, host_en}, 8'h00, "echo host off");
        echo_chk(8'h96);
        chan = URXF_CHAN_REMOTE;
        cyc(1);
        chk({host_en, rx_data[6:0]}, 8'h00, "remote cut");
        echo_chk(8'h69);
        pulse(5);
        chan = URXF_CHAN_NORMAL;
        cyc(1);
        rd(8'h96);
        close_out();
    end
endmodule : testbench
